//--- rtl/stf_pkg.sv
// Shared constants and state types of the shadow task file block.
// Assumes one 100 MHz clock and a host register port on that clock.
package stf_pkg;
    // ------------------------------------------------------------
    // Register port addresses
    // ------------------------------------------------------------
    localparam logic [3:0] ADR_FAIL = 4'h1;   // Read failure_cause, write features.
    localparam logic [3:0] ADR_COUNT = 4'h2;  // Sector count.
    localparam logic [3:0] ADR_LOW = 4'h3;    // Low address byte.
    localparam logic [3:0] ADR_MID = 4'h4;    // Mid address byte.
    localparam logic [3:0] ADR_HIGH = 4'h5;   // High address byte.
    localparam logic [3:0] ADR_UNIT = 4'h6;   // unit_and_head_select.
    localparam logic [3:0] ADR_CMD = 4'h7;    // Read drive_condition, write command.
    localparam logic [3:0] ADR_CTRL = 4'h8;   // Write drive_control, read alternate condition.
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTL_UPPER_BYTE_READBACK = 7;
    localparam int CTL_SOFT_RESET_HOLD = 2;
    localparam int CTL_HOST_IRQ_DISABLE = 1;
    localparam int UNIT_LBA_MODE = 6;
    localparam int UNIT_CHOICE = 4;
    localparam logic [7:0] FAIL_MASK = 8'hd7;  // Bits 5 and 3 always read zero.
    localparam int FAIL_COMMAND_ABORTED = 2;
    // ------------------------------------------------------------
    // Values after reset and fixed values
    // ------------------------------------------------------------
    localparam logic [7:0] UNIT_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] FAIL_RESET = 8'h00;
    localparam logic UNIT_ID = 1'b0;           // This drive answers as unit 0.
    localparam logic [7:0] FRAME_PIO_SETUP = 8'h34;
    localparam logic [7:0] FRAME_DMA_ACTIVATE = 8'h39;
    localparam int FRAME_IRQ_BIT = 14;
    localparam logic [2:0] LEN_PIO_SETUP = 3'h5;
    localparam logic [2:0] LEN_DMA_ACTIVATE = 3'h1;
    localparam logic [16:0] COUNT_ZERO_28 = 17'h00100;  // 256 sectors.
    localparam logic [16:0] COUNT_ZERO_48 = 17'h10000;  // 65,536 sectors.
    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef struct packed {
        logic busy;
        logic ready;
        logic fault;
        logic transfer_request_flag;
        logic err;
        logic irq;
        logic [7:0] ctrl;
        logic [7:0] unitHead;
        logic [7:0] failReg;
        logic [7:0] cmd;
        logic cmdGo;
        logic [7:0] rdata;
    } stf_core_s;
    typedef struct packed {
        logic [7:0] latest;
        logic [7:0] prev;
    } stf_hist_s;
    typedef struct packed {
        logic active;
        logic [2:0] left;
        logic [159:0] words;
    } stf_frame_s;
endpackage

//--- rtl/stf_hist_byte.sv
// Byte register that keeps its latest and its previous write.
// Assumes write and load strobes are one-cycle pulses on clk.
`timescale 1ns/100ps
module stf_hist_byte
    import stf_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hostWrite,
    input wire logic [7:0] hostData,
    input wire logic load,
    input wire logic [7:0] loadLatest,
    input wire logic [7:0] loadPrev,
    output logic [7:0] latest,
    output logic [7:0] prev
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    stf_hist_s st;       // Registered copy.
    stf_hist_s next_st;  // Next copy.

    // A host write pushes the old byte down; a device load replaces both,
    // and wins because it reports the finished command.
    always_comb begin
        next_st = st;
        if (load) begin
            next_st.latest = loadLatest;
            next_st.prev = loadPrev;
        end else if (hostWrite) begin
            next_st.prev = st.latest;
            next_st.latest = hostData;
        end
    end

    // Synchronous reset to zero.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign latest = st.latest;
    assign prev = st.prev;
endmodule

//--- rtl/stf_frame_tx.sv
// Sends a frame of up to five dwords, lowest dword first.
// Assumes the link layer takes a dword when valid and ready are both high.
`timescale 1ns/100ps
module stf_frame_tx
    import stf_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic [2:0] length,
    input wire logic [159:0] words,
    output logic frameBusy,
    output logic [31:0] fisWord,
    output logic fisValid,
    output logic fisLast,
    input wire logic fisReady
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    stf_frame_s st;       // Registered copy.
    stf_frame_s next_st;  // Next copy.

    // Start is honoured only when idle; the caller watches frameBusy.
    always_comb begin
        next_st = st;
        if (!st.active) begin
            if (start) begin
                next_st.active = 1'b1;
                next_st.left = length;
                next_st.words = words;
            end
        end else if (fisReady) begin
            next_st.words = {32'h0, st.words[159:32]};
            next_st.left = st.left - 3'h1;
            next_st.active = (st.left != 3'h1);
        end
    end

    // Synchronous reset.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign frameBusy = st.active;
    assign fisValid = st.active;
    assign fisWord = st.words[31:0];
    assign fisLast = st.active && (st.left == 3'h1);
endmodule

//--- rtl/stf_task_file.sv
// Device-side shadow task file: host register port, status and error
// reporting, interrupt line and the device-to-host frame builder.
// Assumes the command engine and link layer run on the same clock.
//
// How it works
// - Write DMA: send one-dword activate frame 39h.
// - PIO setup frame carries status, counts, address.
// - Command register write starts execution immediately.
// - Command-block writes clear upper byte readback.
// - Soft reset hold keeps device occupied.
// - Interrupt only when enabled and unit selected.
// - Irq disable still sets frame interrupt flag.
// - Bit 6 picks CHS or block addressing.
// - Low nibble holds address bits 24-27.
// - Failure cause bit layout, bits 5,3 zero.
// - Rejected commands set command aborted.
// - High register rewritten with bits 16-23.
// - Mid register: bits 8-15, previous 32-39.
// - Low register: bits 0-7, previous 24-31.
// - Zero count means 256 or 65,536.
// - Count zero on success, else remaining.
// - Status updated on error and completion.
// - Status read acknowledges pending interrupt.
// - While occupied, reads return status; command-block writes ignored.
// - Accepting commands only when device is able.
// - Write fault flag cleared by status read.
// - Error bit set on failure, cleared next command.
`timescale 1ns/100ps
module stf_task_file
    import stf_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    output logic host_irq_line,
    output logic cmdStart,
    output logic [7:0] cmdCode,
    output logic [47:0] requestLba,
    output logic [15:0] requestFeatures,
    output logic lbaMode,
    output logic [16:0] sectorTotal,
    input wire logic cmdIs48,
    input wire logic deviceAble,
    input wire logic drqSet,
    input wire logic drqClear,
    input wire logic writeFaultEvent,
    input wire logic doneStrobe,
    input wire logic doneOk,
    input wire logic [7:0] doneFail,
    input wire logic [15:0] doneRemaining,
    input wire logic [47:0] doneLba,
    input wire logic sendPioSetup,
    input wire logic [15:0] pioXferCount,
    input wire logic sendDmaActivate,
    output logic frameBusy,
    output logic [31:0] fisWord,
    output logic fisValid,
    output logic fisLast,
    input wire logic fisReady
);
    // ------------------------------------------------------------
    // State and decode
    // ------------------------------------------------------------
    stf_core_s st;            // Registered copy of all core state.
    stf_core_s next_st;       // Next copy.
    logic [7:0] status;       // drive_condition as the host sees it.
    logic wrAny;              // Host write that is not ignored.
    logic cmdBlockWrite;      // Write to any command-block register.
    logic cmdAccept;          // Command write that starts execution.
    logic cmdReject;          // Command write refused by own state.
    logic statusRead;         // Host read of the condition register.
    logic [4:0][7:0] latestB; // Latest bytes: count, low, mid, high, features.
    logic [4:0][7:0] prevB;   // Previous bytes of the same.
    logic [4:0][7:0] loadL;   // Completion values for latest bytes.
    logic [4:0][7:0] loadP;   // Completion values for previous bytes.
    logic [4:0] hostWr;       // Per-byte host write strobes.
    logic [159:0] frameWords; // Frame image handed to the sender.
    logic [2:0] frameLen;     // Dword count of that frame.
    logic irqFlag;            // The I bit placed in PIO setup frames.

    // Seek-complete follows ready; corrected and index read zero.
    assign status = {st.busy, st.ready, st.fault, st.ready, st.transfer_request_flag, 2'b00, st.err};

    // While occupied, command-block writes are dropped; control always lands.
    assign wrAny = regWrite && (!st.busy || regAddr == ADR_CTRL);
    assign cmdBlockWrite = wrAny && (regAddr != ADR_CTRL);
    assign statusRead = regRead && (regAddr == ADR_CMD);
    assign cmdAccept = cmdBlockWrite && (regAddr == ADR_CMD) && st.ready && !st.transfer_request_flag;
    assign cmdReject = cmdBlockWrite && (regAddr == ADR_CMD) && !(st.ready && !st.transfer_request_flag);

    // ------------------------------------------------------------
    // Address and count byte pairs
    // ------------------------------------------------------------
    // Completion images: the device writes back where it stopped.
    always_comb begin
        loadL[0] = doneOk ? 8'h00 : doneRemaining[7:0];
        loadP[0] = doneOk ? 8'h00 : doneRemaining[15:8];
        loadL[1] = doneLba[7:0];
        loadP[1] = doneLba[31:24];
        loadL[2] = doneLba[15:8];
        loadP[2] = doneLba[39:32];
        loadL[3] = doneLba[23:16];
        loadP[3] = doneLba[47:40];
        loadL[4] = latestB[4];
        loadP[4] = prevB[4];
    end

    // Count, low, mid and high sit at consecutive addresses; features last.
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_byte
            if (gi < 4) begin : g_addr
                assign hostWr[gi] = cmdBlockWrite && (regAddr == ADR_COUNT + 4'(gi));
            end else begin : g_feat
                assign hostWr[gi] = cmdBlockWrite && (regAddr == ADR_FAIL);
            end
            stf_hist_byte u_byte (
                .clk(clk),
                .sys_rst(sys_rst),
                .hostWrite(hostWr[gi]),
                .hostData(regWdata),
                .load(doneStrobe && (gi < 4)),
                .loadLatest(loadL[gi]),
                .loadPrev(loadP[gi]),
                .latest(latestB[gi]),
                .prev(prevB[gi])
            );
        end
    endgenerate

    // Block address as the command engine sees it; CHS reuses the same bytes.
    assign requestLba = {prevB[3], prevB[2], prevB[1], latestB[3], latestB[2], latestB[1]};
    assign requestFeatures = {prevB[4], latestB[4]};
    assign lbaMode = st.unitHead[UNIT_LBA_MODE];

    // A zero count stands for a full count of the addressing width.
    always_comb begin
        if (cmdIs48) begin
            sectorTotal = ({prevB[0], latestB[0]} == 16'h0) ? COUNT_ZERO_48 : {1'b0, prevB[0], latestB[0]};
        end else begin
            sectorTotal = (latestB[0] == 8'h0) ? COUNT_ZERO_28 : {9'h0, latestB[0]};
        end
    end

    // ------------------------------------------------------------
    // Core state update
    // ------------------------------------------------------------
    // Events that set a flag are applied after the clears, so a set that
    // meets an acknowledge in the same cycle survives.
    always_comb begin
        next_st = st;
        next_st.cmdGo = 1'b0;
        next_st.ready = deviceAble && !st.ctrl[CTL_SOFT_RESET_HOLD];
        if (cmdBlockWrite) begin
            next_st.ctrl[CTL_UPPER_BYTE_READBACK] = 1'b0;
        end
        if (wrAny && regAddr == ADR_CTRL) begin
            next_st.ctrl = regWdata & 8'h86;
        end
        if (cmdBlockWrite && regAddr == ADR_UNIT) begin
            next_st.unitHead = regWdata;
        end
        if (statusRead) begin
            next_st.irq = 1'b0;
            next_st.fault = 1'b0;
        end
        if (drqClear) begin
            next_st.transfer_request_flag = 1'b0;
        end
        if (drqSet) begin
            next_st.transfer_request_flag = 1'b1;
        end
        if (cmdAccept) begin
            next_st.cmd = regWdata;
            next_st.cmdGo = 1'b1;
            next_st.busy = 1'b1;
            next_st.err = 1'b0;
            next_st.failReg = FAIL_RESET;
        end
        if (cmdReject) begin
            next_st.err = 1'b1;
            next_st.failReg = FAIL_RESET;
            next_st.failReg[FAIL_COMMAND_ABORTED] = 1'b1;
            next_st.irq = 1'b1;
        end
        if (doneStrobe) begin
            next_st.busy = 1'b0;
            next_st.transfer_request_flag = 1'b0;
            next_st.err = !doneOk;
            next_st.failReg = doneOk ? FAIL_RESET : (doneFail & FAIL_MASK);
            next_st.irq = 1'b1;
            if (st.unitHead[UNIT_LBA_MODE]) begin
                next_st.unitHead[3:0] = doneLba[27:24];
            end
        end
        if (writeFaultEvent) begin
            next_st.fault = 1'b1;
            next_st.irq = 1'b1;
        end
        if (st.ctrl[CTL_SOFT_RESET_HOLD]) begin
            // Held in reset: nothing pending, no transfer. Occupied while the bit
            // stays set; the write that clears it frees the device at once, so a
            // command cut short by the reset cannot leave the device stuck busy.
            next_st.busy = next_st.ctrl[CTL_SOFT_RESET_HOLD];
            next_st.transfer_request_flag = 1'b0;
            next_st.irq = 1'b0;
            next_st.cmdGo = 1'b0;
        end
        // Read data: while occupied every address returns the condition byte.
        if (st.busy) begin
            next_st.rdata = status;
        end else begin
            case (regAddr)
                ADR_FAIL: next_st.rdata = st.failReg;
                ADR_COUNT: next_st.rdata = st.ctrl[7] ? prevB[0] : latestB[0];
                ADR_LOW: next_st.rdata = st.ctrl[7] ? prevB[1] : latestB[1];
                ADR_MID: next_st.rdata = st.ctrl[7] ? prevB[2] : latestB[2];
                ADR_HIGH: next_st.rdata = st.ctrl[7] ? prevB[3] : latestB[3];
                ADR_UNIT: next_st.rdata = st.unitHead;
                ADR_CMD: next_st.rdata = status;
                ADR_CTRL: next_st.rdata = status;
                default: next_st.rdata = 8'h00;
            endcase
        end
        if (st.cmdGo) begin
            next_st.cmd = st.cmd;
        end
    end

    // Synchronous reset: not ready and not occupied until the engine says so.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
            st.ctrl <= CTRL_RESET;
            st.unitHead <= UNIT_RESET;
            st.failReg <= FAIL_RESET;
        end else begin
            st <= next_st;
        end
    end

    // The line is a gate on the pending flag, so disabling it loses nothing.
    assign host_irq_line = st.irq && !st.ctrl[CTL_HOST_IRQ_DISABLE] && (st.unitHead[UNIT_CHOICE] == UNIT_ID);
    assign regRdata = st.rdata;
    assign cmdStart = st.cmdGo;
    assign cmdCode = st.cmd;

    // ------------------------------------------------------------
    // Outgoing frames
    // ------------------------------------------------------------
    assign irqFlag = st.irq || st.ctrl[CTL_HOST_IRQ_DISABLE];

    // PIO setup wins when both are asked in one cycle; the activate is dropped.
    always_comb begin
        frameWords = '0;
        frameLen = LEN_DMA_ACTIVATE;
        if (sendPioSetup) begin
            frameLen = LEN_PIO_SETUP;
            frameWords[7:0] = FRAME_PIO_SETUP;
            frameWords[FRAME_IRQ_BIT] = irqFlag;
            frameWords[23:16] = status;
            frameWords[31:24] = st.failReg;
            frameWords[63:32] = {st.unitHead, latestB[3], latestB[2], latestB[1]};
            frameWords[87:64] = {prevB[3], prevB[2], prevB[1]};
            frameWords[111:96] = {prevB[0], latestB[0]};
            frameWords[127:120] = {1'b0, status[6:4], 1'b0, status[2:0]};
            frameWords[143:128] = pioXferCount;
        end else begin
            frameWords[7:0] = FRAME_DMA_ACTIVATE;
        end
    end

    stf_frame_tx u_frame (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(sendPioSetup || sendDmaActivate),
        .length(frameLen),
        .words(frameWords),
        .frameBusy(frameBusy),
        .fisWord(fisWord),
        .fisValid(fisValid),
        .fisLast(fisLast),
        .fisReady(fisReady)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Busy is asked for only while the hold bit still stands a cycle later:
    // the host may set and clear it back to back, and the clear frees the device.
    hold_busy_a: assert property (@(posedge clk) disable iff (sys_rst)
        st.ctrl[CTL_SOFT_RESET_HOLD] |=> (st.busy || !st.ctrl[CTL_SOFT_RESET_HOLD]))
        else $error("busy dropped during soft reset hold");
    hob_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        cmdBlockWrite |=> !st.ctrl[CTL_UPPER_BYTE_READBACK])
        else $error("readback select survived a command-block write");
    irq_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        host_irq_line |-> (st.irq && !st.ctrl[1] && st.unitHead[4] == UNIT_ID))
        else $error("interrupt line while disabled or unselected");
    irq_ack_a: assert property (@(posedge clk) disable iff (sys_rst)
        (statusRead && !doneStrobe && !cmdReject && !writeFaultEvent) |=> !host_irq_line)
        else $error("status read did not clear pending interrupt");
    cmd_start_a: assert property (@(posedge clk) disable iff (sys_rst)
        cmdAccept |=> (cmdStart && cmdCode == $past(regWdata) && !st.err) ##1 !cmdStart)
        else $error("command write did not start exactly once");
    count_done_a: assert property (@(posedge clk) disable iff (sys_rst)
        (doneStrobe && doneOk) |=> (latestB[0] == 8'h00 && !st.err && st.irq))
        else $error("count not zero after successful completion");
    busy_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        (st.busy && regRead) |=> regRdata == $past(status))
        else $error("read while occupied did not return status");
    // A status read in the same cycle as the fault must not hide it.
    fault_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        writeFaultEvent |=> st.fault)
        else $error("write fault not flagged");
    abort_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        cmdReject |=> (st.err && st.failReg[FAIL_COMMAND_ABORTED]))
        else $error("rejected command not marked aborted");
    // Ready may only follow the engine one cycle late, never lead it.
    ready_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        !deviceAble |=> !st.ready)
        else $error("ready raised while the engine cannot accept");
    fail_layout_a: assert property (@(posedge clk) disable iff (sys_rst)
        (st.failReg & ~FAIL_MASK) == 8'h00)
        else $error("reserved failure cause bits set");
    // The activate frame is a single dword holding nothing but its type code.
    activate_frame_a: assert property (@(posedge clk) disable iff (sys_rst)
        (sendDmaActivate && !sendPioSetup && !frameBusy) |=>
        (fisValid && fisLast && fisWord == {24'h000000, FRAME_DMA_ACTIVATE}))
        else $error("activate frame malformed");
    // With the line disabled the frame flag must still be raised.
    frame_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
        (sendPioSetup && !frameBusy && st.ctrl[CTL_HOST_IRQ_DISABLE]) |=> fisWord[FRAME_IRQ_BIT])
        else $error("interrupt flag missing from setup frame");
endmodule

//--- dv/stf_host_sink.sv
// Host-side frame sink model: takes frame dwords and keeps them by position.
// Assumes the valid/ready handshake of the frame sender on clk.
`timescale 1ns/100ps
module stf_host_sink (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [31:0] fisWord,
    input wire logic fisValid,
    input wire logic fisLast,
    output logic fisReady,
    output logic [159:0] capWords
);
    logic [2:0] idx; // Next dword slot of the frame.
    // Ready toggles every cycle, so the sender must hold a dword through a stall.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fisReady <= 1'h0;
            idx <= 3'h0;
        end else begin
            fisReady <= ~fisReady;
            if (fisValid && fisReady) begin
                capWords[idx*32 +: 32] <= fisWord;
                idx <= fisLast ? 3'h0 : idx + 3'h1;
            end
        end
    end
endmodule

//--- dv/tb.sv
// Self-checking bench of the shadow task file.
// Assumes the host sink model on the frame port.
`timescale 1ns/100ps
module tb;
    import stf_pkg::*;
    logic clk = 1'h0;
    logic sys_rst = 1'h1;
    logic [3:0] regAddr = 4'h0;
    logic regWrite = 1'h0, regRead = 1'h0, cmdIs48 = 1'h0, deviceAble = 1'h0, drqSet = 1'h0;
    logic drqClear = 1'h0, writeFaultEvent = 1'h0, doneStrobe = 1'h0, doneOk = 1'h0;
    logic sendPioSetup = 1'h0, sendDmaActivate = 1'h0, started;
    logic [7:0] regWdata = 8'h00, doneFail = 8'h00, rdv, regRdata, cmdCode;
    logic [15:0] doneRemaining = 16'h0000, pioXferCount = 16'h0000, requestFeatures;
    logic [47:0] doneLba = 48'h0, requestLba;
    logic host_irq_line, cmdStart, lbaMode, frameBusy, fisValid, fisLast, fisReady;
    logic [16:0] sectorTotal;
    logic [31:0] fisWord;
    logic [159:0] capWords;
    int failures = 0, checks = 0, cycles = 0;
    stf_task_file stf_task_file_i (.clk, .sys_rst, .regAddr, .regWrite, .regRead, .regWdata,
        .regRdata, .host_irq_line, .cmdStart, .cmdCode, .requestLba, .requestFeatures, .lbaMode,
        .sectorTotal, .cmdIs48, .deviceAble, .drqSet, .drqClear, .writeFaultEvent, .doneStrobe,
        .doneOk, .doneFail, .doneRemaining, .doneLba, .sendPioSetup, .pioXferCount,
        .sendDmaActivate, .frameBusy, .fisWord, .fisValid, .fisLast, .fisReady);
    stf_host_sink stf_host_sink_i (.clk, .sys_rst, .fisWord, .fisValid, .fisLast, .fisReady, .capWords);
    // The clock runs at 100 MHz.
    always #5 clk = ~clk;
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // A write takes two cycles so that the strobe is never reassigned in one step.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        regAddr = a;
        regWdata = d;
        regWrite = 1'h1;
        @(negedge clk);
        regWrite = 1'h0;
        started = cmdStart;
        @(negedge clk);
    endtask
    // Read data is taken one cycle after the strobe edge, masked by m.
    task automatic rc(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
        regAddr = a;
        regRead = 1'h1;
        @(negedge clk);
        regRead = 1'h0;
        rdv = regRdata;
        chk(rdv & m, e);
        @(negedge clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'h1;
        @(negedge clk);
        s = 1'h0;
        @(negedge clk);
    endtask
    // Waits a bounded time for the frame to drain through the stalling sink.
    task automatic wait_frame();
        repeat (40) @(negedge clk);
        chk(frameBusy, 1'h0);
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // A hang is cut short well beyond the expected run of a few hundred cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            final_report();
        end
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(negedge clk);
        sys_rst = 1'h0;
        @(negedge clk);
        rc(ADR_CMD, 8'h00);
        deviceAble = 1'h1;
        repeat (2) @(negedge clk);
        rc(ADR_CMD, 8'h50);
        wr(ADR_COUNT, 8'h00);
        wr(ADR_COUNT, 8'h00);
        chk(sectorTotal, COUNT_ZERO_28);
        cmdIs48 = 1'h1;
        #1 chk(sectorTotal, COUNT_ZERO_48);
        wr(ADR_COUNT, 8'h12);
        wr(ADR_COUNT, 8'h34);
        wr(ADR_CTRL, 8'h80);
        rc(ADR_COUNT, 8'h12);
        wr(ADR_LOW, 8'h11);
        rc(ADR_COUNT, 8'h34);
        $display("test readback done");
        wr(ADR_LOW, 8'h44);
        wr(ADR_MID, 8'h22);
        wr(ADR_MID, 8'h55);
        wr(ADR_HIGH, 8'h33);
        wr(ADR_HIGH, 8'h66);
        wr(ADR_UNIT, 8'h40);
        chk(lbaMode, 1'h1);
        chk(requestLba, 48'h332211665544);
        wr(ADR_FAIL, 8'h0c);
        wr(ADR_FAIL, 8'hd0);
        chk(requestFeatures, 16'h0cd0);
        wr(ADR_CMD, 8'h25);
        chk({started, cmdCode}, 9'h125);
        rc(ADR_LOW, 8'h80, 8'h80);
        wr(ADR_UNIT, 8'h00);
        chk(lbaMode, 1'h1);
        doneFail = 8'hff;
        doneRemaining = 16'h0005;
        doneLba = 48'habcdef123456;
        pulse(doneStrobe);
        chk(host_irq_line, 1'h1);
        rc(ADR_FAIL, 8'hd7);
        rc(ADR_COUNT, 8'h05);
        rc(ADR_LOW, 8'h56);
        rc(ADR_MID, 8'h34);
        rc(ADR_HIGH, 8'h12);
        rc(ADR_UNIT, 8'h0f, 8'h0f);
        wr(ADR_CTRL, 8'h80);
        rc(ADR_LOW, 8'hef);
        rc(ADR_MID, 8'hcd);
        rc(ADR_CMD, 8'h51);
        chk(host_irq_line, 1'h0);
        $display("test failed command done");
        wr(ADR_CTRL, 8'h02);
        wr(ADR_CMD, 8'h20);
        doneOk = 1'h1;
        pulse(doneStrobe);
        chk(host_irq_line, 1'h0);
        rc(ADR_COUNT, 8'h00);
        rc(ADR_CMD, 8'h50);
        pioXferCount = 16'h0200;
        pulse(sendPioSetup);
        wait_frame();
        chk({capWords[14], capWords[7:0]}, {1'h1, FRAME_PIO_SETUP});
        chk({capWords[127:120], capWords[39:32]}, 16'h5056);
        chk(capWords[143:128], 16'h0200);
        pulse(sendDmaActivate);
        wait_frame();
        chk(capWords[31:0], 32'h00000039);
        $display("test frames done");
        wr(ADR_CTRL, 8'h04);
        rc(ADR_CMD, 8'h80, 8'h80);
        wr(ADR_CTRL, 8'h00);
        rc(ADR_CMD, 8'h50);
        pulse(drqSet);
        wr(ADR_CMD, 8'hec);
        chk(started, 1'h0);
        rc(ADR_FAIL, 8'h04, 8'h04);
        rc(ADR_CMD, 8'h59);
        pulse(drqClear);
        pulse(writeFaultEvent);
        rc(ADR_CMD, 8'h71);
        rc(ADR_CMD, 8'h51);
        wr(ADR_UNIT, 8'h10);
        pulse(writeFaultEvent);
        chk(host_irq_line, 1'h0);
        rc(ADR_CMD, 8'h71);
        $display("test reset and refusal done");
        final_report();
    end
endmodule
